// File: src/vitf_pkg.sv
// Constants and types for the vectored interrupt and test flag controller.
// Assumes a single pclk domain and a 32-bit APB slave with byte addresses.
package vitf_pkg;

  // Source counts
  localparam int VITF_NSRC = 17;
  localparam int VITF_NPIN = 6;
  localparam int VITF_NP11 = 8;
  localparam int VITF_IDXW = 5;

  // APB register byte offsets
  localparam logic [7:0] VITF_OFF_REQ = 8'h00;
  localparam logic [7:0] VITF_OFF_MASK = 8'h04;
  localparam logic [7:0] VITF_OFF_PRIO = 8'h08;
  localparam logic [7:0] VITF_OFF_CTRL = 8'h0c;
  localparam logic [7:0] VITF_OFF_EDGE = 8'h10;
  localparam logic [7:0] VITF_OFF_TEST = 8'h14;
  localparam logic [7:0] VITF_OFF_VEC = 8'h18;

  // Field positions
  localparam int VITF_CTRL_GE = 0;
  localparam int VITF_CTRL_ISP = 1;
  localparam int VITF_CTRL_WDTRUN = 2;
  localparam int VITF_CTRL_NMIP = 3;
  localparam int VITF_CTRL_BRKP = 4;
  localparam int VITF_EDGE_RISE_LSB = 0;
  localparam int VITF_EDGE_FALL_LSB = 8;
  localparam int VITF_TEST_FLAG_LSB = 0;
  localparam int VITF_TEST_MASK_LSB = 8;
  localparam int VITF_VEC_PEND_BIT = 16;
  localparam int VITF_TEST_WATCH = 0;
  localparam int VITF_TEST_PORT11 = 1;

  // Reset values
  localparam logic [16:0] VITF_RST_REQ = 17'h00000;
  localparam logic [16:0] VITF_RST_MASK = 17'h1ffff;
  localparam logic [16:0] VITF_RST_PRIO = 17'h1ffff;
  localparam logic VITF_RST_GE = 1'b0;
  localparam logic VITF_RST_ISP = 1'b1;
  localparam logic VITF_RST_WDTRUN = 1'b0;
  localparam logic [5:0] VITF_RST_EDGE = 6'h00;
  localparam logic [1:0] VITF_RST_TMASK = 2'h3;

  // Maskable source indices, equal to default priority
  localparam int VITF_SRC_WDT = 0;
  localparam int VITF_SRC_PIN0 = 1;
  localparam int VITF_SRC_CSI0 = 7;
  localparam int VITF_SRC_SER = 8;
  localparam int VITF_SRC_SR = 9;
  localparam int VITF_SRC_ST = 10;
  localparam int VITF_SRC_TM3 = 11;
  localparam int VITF_SRC_TM00 = 12;
  localparam int VITF_SRC_TM01 = 13;
  localparam int VITF_SRC_TM1 = 14;
  localparam int VITF_SRC_TM2 = 15;
  localparam int VITF_SRC_AD = 16;

  // Vector addresses; table entry i belongs to default priority i
  localparam logic [15:0] VITF_VEC_NMI = 16'h0004;
  localparam logic [15:0] VITF_VEC_BRK = 16'h003e;
  localparam logic [VITF_NSRC-1:0][15:0] VITF_VEC_TABLE = {
    16'h0028, 16'h0026, 16'h0024, 16'h0022, 16'h0020, 16'h001e,
    16'h001c, 16'h001a, 16'h0018, 16'h0014, 16'h0010, 16'h000e,
    16'h000c, 16'h000a, 16'h0008, 16'h0006, 16'h0004};

  // Kind of request being presented to the core
  typedef enum logic [3:0] {
    VITF_G_NONE = 4'b0001,
    VITF_G_NMI = 4'b0010,
    VITF_G_BRK = 4'b0100,
    VITF_G_MASK = 4'b1000
  } vitf_grant_t;

endpackage : vitf_pkg

// File: src/vitf_edge_detect.sv
// Pin synchroniser and selectable edge detector, one lane per bit.
// Assumes asynchronous pins; pulses are one pclk cycle wide.
`timescale 1ns/1ps
`default_nettype none
module vitf_edge_detect #(
  parameter int WIDTH = 6,
  parameter logic IDLE = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin,
  input wire logic [WIDTH-1:0] rise_en,
  input wire logic [WIDTH-1:0] fall_en,
  output logic [WIDTH-1:0] edge_pulse
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] pulse;
  } vitf_edge_t;

  vitf_edge_t st_reg;
  vitf_edge_t st_next;

  // Idle level at reset avoids a false edge on pulled-up pins
  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = pin;
    st_next.s2 = st_reg.s1;
    st_next.prev = st_reg.s2;
    st_next.pulse = (st_reg.s2 & ~st_reg.prev & rise_en)
                  | (~st_reg.s2 & st_reg.prev & fall_en);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '{s1: {WIDTH{IDLE}}, s2: {WIDTH{IDLE}}, prev: {WIDTH{IDLE}}, pulse: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign edge_pulse = st_reg.pulse;

endmodule : vitf_edge_detect
`default_nettype wire

// File: src/vitf_ctrl.sv
// Vectored interrupt controller with two non-vectored test flags.
// Assumes peripheral strobes on pclk, async pins, an APB master and a core ack.
`timescale 1ns/1ps
`default_nettype none
module vitf_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic watchdog_overflow_req,
  input wire logic serial0_done_req,
  input wire logic async_rx_error_req,
  input wire logic async_rx_done_req,
  input wire logic serial2_threewire_done_req,
  input wire logic serial2_uart_mode,
  input wire logic async_tx_done_req,
  input wire logic watch_interval_req,
  input wire logic timer16_match_a_req,
  input wire logic timer16_match_b_req,
  input wire logic timer8_1_match_req,
  input wire logic timer8_2_match_req,
  input wire logic adc_done_req,
  input wire logic break_soft_req,
  input wire logic watch_overflow_test,
  input wire logic [vitf_pkg::VITF_NPIN-1:0] ext_pin,
  input wire logic [vitf_pkg::VITF_NP11-1:0] port_eleven_pins,
  input wire logic intr_ack,
  output logic intr_req,
  output logic intr_nmi,
  output logic [15:0] intr_vector,
  output logic [1:0] test_pending
);
  import vitf_pkg::*;

  typedef struct packed {
    logic [VITF_NSRC-1:0] req;
    logic [VITF_NSRC-1:0] mask;
    logic [VITF_NSRC-1:0] prio;
    logic ge;
    logic in_service_level_flag;
    logic wdt_run;
    logic nmi_pend;
    logic brk_pend;
    logic [1:0] tflag;
    logic [1:0] tmask;
    logic [1:0] tpend;
    logic [VITF_NPIN-1:0] rise_en;
    logic [VITF_NPIN-1:0] fall_en;
    logic irq;
    vitf_grant_t kind;
    logic [VITF_IDXW-1:0] gidx;
    logic [15:0] vector;
    logic [31:0] rdata;
    logic slverr;
    logic [VITF_NSRC-1:0] elig_q;
    logic [VITF_NSRC-1:0] prio_q;
  } vitf_state_t;

  localparam vitf_state_t VITF_STATE_RST = '{
    req: VITF_RST_REQ, mask: VITF_RST_MASK, prio: VITF_RST_PRIO,
    ge: VITF_RST_GE, in_service_level_flag: VITF_RST_ISP, wdt_run: VITF_RST_WDTRUN,
    nmi_pend: 1'b0, brk_pend: 1'b0, tflag: 2'h0, tmask: VITF_RST_TMASK,
    tpend: 2'h0, rise_en: VITF_RST_EDGE, fall_en: VITF_RST_EDGE,
    irq: 1'b0, kind: VITF_G_NONE, gidx: '0, vector: 16'h0000,
    rdata: 32'h00000000, slverr: 1'b0, elig_q: '0, prio_q: '0};
  vitf_state_t st_reg;
  vitf_state_t st_next;
  logic [VITF_NPIN-1:0] pin_edge;
  logic [VITF_NP11-1:0] p11_edge;
  logic [VITF_NSRC-1:0] src;
  logic [VITF_NSRC-1:0] elig;
  logic [VITF_IDXW:0] pick;
  logic apb_wr;
  logic apb_setup;
  logic ack_take;

  // Address decode for the error answer; the read mux decodes paddr in its own case
  function automatic logic vitf_is_mapped(input logic [7:0] addr);
    return (addr == VITF_OFF_REQ) || (addr == VITF_OFF_MASK) || (addr == VITF_OFF_PRIO)
       || (addr == VITF_OFF_CTRL) || (addr == VITF_OFF_EDGE) || (addr == VITF_OFF_TEST)
       || (addr == VITF_OFF_VEC);
  endfunction : vitf_is_mapped

  // High group alone if any is eligible, then lowest index wins the scan
  function automatic logic [VITF_IDXW:0] vitf_pick(
    input logic [VITF_NSRC-1:0] el,
    input logic [VITF_NSRC-1:0] pr
  );
    logic [VITF_IDXW:0] r;
    logic [VITF_NSRC-1:0] s;
    r = '0;
    s = (|(el & ~pr)) ? (el & ~pr) : el;
    for (int i = VITF_NSRC - 1; i >= 0; i--)
    begin
      if (s[i])
      begin
        r = {1'b1, VITF_IDXW'(i)};
      end
    end
    return r;
  endfunction : vitf_pick
  // External interrupt pins, edge chosen per pin by software
  vitf_edge_detect #(.WIDTH(VITF_NPIN), .IDLE(1'b0)) u_pin_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ext_pin),
    .rise_en(st_reg.rise_en),
    .fall_en(st_reg.fall_en),
    .edge_pulse(pin_edge)
  );
  // Port 11 pins idle high under pull-ups; only falls count
  vitf_edge_detect #(.WIDTH(VITF_NP11), .IDLE(1'b1)) u_p11_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(port_eleven_pins),
    .rise_en({VITF_NP11{1'b0}}),
    .fall_en({VITF_NP11{1'b1}}),
    .edge_pulse(p11_edge)
  );

  // Source strobes gathered into the request vector
  always_comb
  begin
    src = '0;
    src[VITF_SRC_WDT] = watchdog_overflow_req & ~st_reg.wdt_run;
    src[VITF_SRC_PIN0 +: VITF_NPIN] = pin_edge;
    src[VITF_SRC_CSI0] = serial0_done_req;
    src[VITF_SRC_SER] = async_rx_error_req;
    src[VITF_SRC_SR] = serial2_uart_mode ? async_rx_done_req : serial2_threewire_done_req;
    src[VITF_SRC_ST] = async_tx_done_req;
    src[VITF_SRC_TM3] = watch_interval_req;
    src[VITF_SRC_TM00] = timer16_match_a_req;
    src[VITF_SRC_TM01] = timer16_match_b_req;
    src[VITF_SRC_TM1] = timer8_1_match_req;
    src[VITF_SRC_TM2] = timer8_2_match_req;
    src[VITF_SRC_AD] = adc_done_req;
  end

  // Eligibility gate; in-service low means a high-group handler runs
  assign elig = st_reg.req & ~st_reg.mask & {VITF_NSRC{st_reg.ge & st_reg.in_service_level_flag}};
  assign pick = vitf_pick(elig, st_reg.prio);
  assign apb_wr = psel & penable & pwrite;
  assign apb_setup = psel & ~penable;
  assign ack_take = intr_ack & st_reg.irq;

  // Next state: software, then acceptance, then hardware sets so sets win
  always_comb
  begin
    st_next = st_reg;
    if (apb_wr)
    begin
      case (paddr)
        VITF_OFF_REQ: st_next.req = st_reg.req & ~pwdata[VITF_NSRC-1:0];
        VITF_OFF_MASK: st_next.mask = pwdata[VITF_NSRC-1:0];
        VITF_OFF_PRIO: st_next.prio = pwdata[VITF_NSRC-1:0];
        VITF_OFF_CTRL:
        begin
          st_next.ge = pwdata[VITF_CTRL_GE];
          st_next.in_service_level_flag = pwdata[VITF_CTRL_ISP];
          st_next.wdt_run = pwdata[VITF_CTRL_WDTRUN];
        end
        VITF_OFF_EDGE:
        begin
          st_next.rise_en = pwdata[VITF_EDGE_RISE_LSB +: VITF_NPIN];
          st_next.fall_en = pwdata[VITF_EDGE_FALL_LSB +: VITF_NPIN];
        end
        VITF_OFF_TEST:
        begin
          st_next.tflag = st_reg.tflag & ~pwdata[VITF_TEST_FLAG_LSB +: 2];
          st_next.tmask = pwdata[VITF_TEST_MASK_LSB +: 2];
        end
        default: st_next.req = st_next.req;
      endcase
    end
    // Core took the presented vector: retire it, block further nesting
    if (ack_take)
    begin
      case (st_reg.kind)
        VITF_G_NMI:
        begin
          st_next.nmi_pend = 1'b0;
          st_next.ge = 1'b0;
        end
        VITF_G_BRK:
        begin
          st_next.brk_pend = 1'b0;
          st_next.ge = 1'b0;
        end
        VITF_G_MASK:
        begin
          st_next.req[st_reg.gidx] = 1'b0;
          st_next.ge = 1'b0;
          st_next.in_service_level_flag = st_reg.prio[st_reg.gidx];
        end
        default: st_next.ge = st_next.ge;
      endcase
    end
    // Hardware sets last, so a set in the clearing cycle survives
    st_next.req = st_next.req | src;
    st_next.nmi_pend = st_next.nmi_pend | (watchdog_overflow_req & st_reg.wdt_run);
    st_next.brk_pend = st_next.brk_pend | break_soft_req;
    st_next.tflag[VITF_TEST_WATCH] = st_next.tflag[VITF_TEST_WATCH] | watch_overflow_test;
    st_next.tflag[VITF_TEST_PORT11] = st_next.tflag[VITF_TEST_PORT11] | (|p11_edge);
    st_next.tpend = st_reg.tflag & ~st_reg.tmask;
    st_next.elig_q = elig;
    st_next.prio_q = st_reg.prio;
    // Pre-ack flags arbitrate, so an ack drops the stale request; NMI ungated
    if (st_reg.nmi_pend)
    begin
      st_next.irq = ~ack_take;
      st_next.kind = VITF_G_NMI;
      st_next.vector = VITF_VEC_NMI;
    end
    else if (st_reg.brk_pend)
    begin
      st_next.irq = ~ack_take;
      st_next.kind = VITF_G_BRK;
      st_next.vector = VITF_VEC_BRK;
    end
    else if (pick[VITF_IDXW])
    begin
      st_next.irq = ~ack_take;
      st_next.kind = VITF_G_MASK;
      st_next.gidx = pick[VITF_IDXW-1:0];
      st_next.vector = VITF_VEC_TABLE[pick[VITF_IDXW-1:0]];
    end
    else
    begin
      st_next.irq = 1'b0;
      st_next.kind = VITF_G_NONE;
    end
    // Read data and error settle in the setup cycle for a zero-wait access
    if (apb_setup)
    begin
      st_next.rdata = 32'h00000000;
      st_next.slverr = ~vitf_is_mapped(paddr);
      case (paddr)
        VITF_OFF_REQ: st_next.rdata[VITF_NSRC-1:0] = st_reg.req;
        VITF_OFF_MASK: st_next.rdata[VITF_NSRC-1:0] = st_reg.mask;
        VITF_OFF_PRIO: st_next.rdata[VITF_NSRC-1:0] = st_reg.prio;
        VITF_OFF_CTRL:
        begin
          st_next.rdata[VITF_CTRL_GE] = st_reg.ge;
          st_next.rdata[VITF_CTRL_ISP] = st_reg.in_service_level_flag;
          st_next.rdata[VITF_CTRL_WDTRUN] = st_reg.wdt_run;
          st_next.rdata[VITF_CTRL_NMIP] = st_reg.nmi_pend;
          st_next.rdata[VITF_CTRL_BRKP] = st_reg.brk_pend;
        end
        VITF_OFF_EDGE:
        begin
          st_next.rdata[VITF_EDGE_RISE_LSB +: VITF_NPIN] = st_reg.rise_en;
          st_next.rdata[VITF_EDGE_FALL_LSB +: VITF_NPIN] = st_reg.fall_en;
        end
        VITF_OFF_TEST:
        begin
          st_next.rdata[VITF_TEST_FLAG_LSB +: 2] = st_reg.tflag;
          st_next.rdata[VITF_TEST_MASK_LSB +: 2] = st_reg.tmask;
        end
        VITF_OFF_VEC:
        begin
          st_next.rdata[15:0] = st_reg.vector;
          st_next.rdata[VITF_VEC_PEND_BIT] = st_reg.irq;
        end
        default: st_next.rdata = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= VITF_STATE_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs; slave never inserts wait states
  assign pready = 1'b1;
  assign prdata = st_reg.rdata;
  assign pslverr = st_reg.slverr;
  assign intr_req = st_reg.irq;
  assign intr_nmi = st_reg.irq && (st_reg.kind == VITF_G_NMI);
  assign intr_vector = st_reg.vector;
  assign test_pending = st_reg.tpend;

  // Helper for the default order check: sources ranked above the winner
  logic [VITF_NSRC-1:0] above_mask;
  logic [VITF_NSRC-1:0] same_grp;
  assign above_mask = (VITF_NSRC'(1) << st_reg.gidx) - VITF_NSRC'(1);
  assign same_grp = ~(st_reg.prio_q ^ {VITF_NSRC{st_reg.prio_q[st_reg.gidx]}});
  a_nmi_vector: assert property (@(posedge pclk) disable iff (!presetn)
    intr_nmi |-> intr_vector == 16'h0004)
    else $error("non-maskable request shows wrong vector");
  a_nmi_ungated: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg.nmi_pend && !ack_take && !st_reg.ge) |=> intr_req && intr_nmi)
    else $error("non-maskable request not presented while disabled");
  a_wdt_interval: assert property (@(posedge pclk) disable iff (!presetn)
    (watchdog_overflow_req && !st_reg.wdt_run && !st_reg.nmi_pend) |=> st_reg.req[0] && !st_reg.nmi_pend)
    else $error("interval overflow did not set priority 0 request");
  a_pin_vector: assert property (@(posedge pclk) disable iff (!presetn)
    (intr_req && st_reg.kind == VITF_G_MASK && st_reg.gidx >= 5'd1 && st_reg.gidx <= 5'd6)
    |-> intr_vector == 16'h0006 + {10'h000, st_reg.gidx - 5'd1, 1'b0})
    else $error("pin request vector out of step");
  a_default_order: assert property (@(posedge pclk) disable iff (!presetn)
    (intr_req && st_reg.kind == VITF_G_MASK) |-> (st_reg.elig_q & above_mask & same_grp) == '0)
    else $error("higher default priority request was passed over");
  a_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (!st_reg.ge && !st_reg.nmi_pend && !st_reg.brk_pend) |=> !intr_req)
    else $error("maskable request presented while globally disabled");
  a_ack_retire: assert property (@(posedge pclk) disable iff (!presetn)
    (ack_take && st_reg.kind == VITF_G_MASK) |=> !intr_req && !st_reg.ge)
    else $error("accepted request not retired");
  a_shared_rx: assert property (@(posedge pclk) disable iff (!presetn)
    (serial2_uart_mode && async_rx_done_req) |=> st_reg.req[9])
    else $error("uart receive completion did not set shared request");
  a_port11_set: assert property (@(posedge pclk) disable iff (!presetn)
    (|p11_edge) |=> st_reg.tflag[1] ##1 (test_pending[1] || st_reg.tmask[1] || !st_reg.tflag[1]))
    else $error("port 11 fall did not set test flag");
  a_test_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg.tflag[0] && !(apb_wr && paddr == VITF_OFF_TEST && pwdata[VITF_TEST_WATCH]))
    |=> st_reg.tflag[0])
    else $error("watch test flag dropped without software clear");
  c_nmi_taken: cover property (@(posedge pclk) disable iff (!presetn)
    intr_nmi && intr_ack);
  c_mask_taken: cover property (@(posedge pclk) disable iff (!presetn)
    intr_req && st_reg.kind == VITF_G_MASK && intr_ack);
  c_brk_taken: cover property (@(posedge pclk) disable iff (!presetn)
    intr_req && st_reg.kind == VITF_G_BRK && intr_ack);
  c_port11_seen: cover property (@(posedge pclk) disable iff (!presetn)
    test_pending[1]);

endmodule : vitf_ctrl
`default_nettype wire

// File: verif/vitf_core_model.sv
// Core model: takes each presented vector after a chosen number of cycles.
// Assumes the controller holds intr_req and the vector until the ack edge.
`timescale 1ns/1ps
`default_nettype none
module vitf_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] ack_delay,
  input wire logic intr_req,
  input wire logic intr_nmi,
  input wire logic [15:0] intr_vector,
  output logic intr_ack,
  output logic [15:0] taken_vector,
  output logic taken_nmi,
  output logic [7:0] acks
);
  logic [3:0] wait_cnt;
  // One-cycle ack pulse; never acks twice for one request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      intr_ack <= 1'b0;
      taken_vector <= 16'h0000;
      taken_nmi <= 1'b0;
      acks <= 8'h00;
      wait_cnt <= 4'h0;
    end
    else
    begin
      intr_ack <= 1'b0;
      if (intr_req && !intr_ack)
      begin
        if (wait_cnt == ack_delay)
        begin
          intr_ack <= 1'b1;
          taken_vector <= intr_vector;
          taken_nmi <= intr_nmi;
          acks <= acks + 8'h01;
          wait_cnt <= 4'h0;
        end
        else
          wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : vitf_core_model
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the interrupt controller, driven over APB.
// Assumes pready answers on its own; core acks come from the model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vitf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, intr_ack, intr_req, intr_nmi, taken_nmi, uart = 1'b1;
  logic [18:0] stim = 19'h0;
  logic [5:0] ext_pin = 6'h00;
  logic [7:0] p11 = 8'hff, acks, n;
  logic [3:0] dly = 4'h0;
  logic [15:0] intr_vector, taken_vector;
  logic [1:0] test_pending;
  int miscompares = 0, num_checks = 0, cycles = 0;
  always #20 pclk = ~pclk;
  vitf_ctrl i_vitf_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .watchdog_overflow_req(stim[0]), .serial0_done_req(stim[7]),
    .async_rx_error_req(stim[8]), .async_rx_done_req(stim[9] & uart),
    .serial2_threewire_done_req(stim[9] & ~uart), .serial2_uart_mode(uart),
    .async_tx_done_req(stim[10]), .watch_interval_req(stim[11]),
    .timer16_match_a_req(stim[12]), .timer16_match_b_req(stim[13]),
    .timer8_1_match_req(stim[14]), .timer8_2_match_req(stim[15]), .adc_done_req(stim[16]),
    .break_soft_req(stim[17]), .watch_overflow_test(stim[18]), .ext_pin(ext_pin),
    .port_eleven_pins(p11), .intr_ack(intr_ack), .intr_req(intr_req), .intr_nmi(intr_nmi),
    .intr_vector(intr_vector), .test_pending(test_pending));
  vitf_core_model i_vitf_core_model (.pclk(pclk), .presetn(presetn), .ack_delay(dly),
    .intr_req(intr_req), .intr_nmi(intr_nmi), .intr_vector(intr_vector), .intr_ack(intr_ack),
    .taken_vector(taken_vector), .taken_nmi(taken_nmi), .acks(acks));
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: register %h, wanted %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: output %h, wanted %h", $time, got, exp);
    end
  endtask : chk_out
  // Setup then access; held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_reg(q, exp);
  endtask : rd
  task automatic pulse(input logic [18:0] m);
    @(posedge pclk);
    stim <= m;
    @(posedge pclk);
    stim <= 19'h0;
  endtask : pulse
  // Bounded wait for the model to take one more vector
  task automatic wait_ack(input logic [7:0] n0);
    for (int k = 0; k < 60 && acks == n0; k++) @(posedge pclk);
    chk_out(16'(acks), 16'(n0 + 8'h01));
  endtask : wait_ack
  function automatic logic [15:0] exp_vector(input int i);
    if (i == 0) return 16'h0004;
    if (i <= 6) return 16'(16'h0006 + 2 * (i - 1));
    if (i == 7) return 16'h0014;
    return 16'(16'h0018 + 2 * (i - 8));
  endfunction : exp_vector
  // Unmask one pending source, enable, expect its vector and clean state
  task automatic service(input int i);
    n = acks;
    apb(1'b1, VITF_OFF_MASK, ~(32'h1 << i) & 32'h1ffff);
    chk_out(16'(intr_req), 16'h0);
    apb(1'b1, VITF_OFF_CTRL, 32'h3);
    wait_ack(n);
    chk_out(taken_vector, exp_vector(i));
    rd(VITF_OFF_CTRL, 32'h2);
    rd(VITF_OFF_REQ, 32'h0);
    apb(1'b1, VITF_OFF_MASK, 32'h1ffff);
  endtask : service
  task automatic t_reset();
    rd(VITF_OFF_MASK, 32'h1ffff);
    rd(VITF_OFF_PRIO, 32'h1ffff);
    rd(VITF_OFF_CTRL, 32'h2);
    rd(VITF_OFF_TEST, 32'h300);
    rd(8'h40, 32'h0);
    chk_out(16'(pslverr), 16'h1);
    $display("test reset done");
  endtask : t_reset
  // Every strobed source held back while masked, then vectored
  task automatic t_strobes();
    for (int i = 0; i < 17; i++)
    begin
      if (i != 0 && i < 7) continue;
      pulse(19'h1 << i);
      repeat (3) @(posedge pclk);
      rd(VITF_OFF_REQ, 32'h1 << i);
      service(i);
    end
    uart <= 1'b0;
    pulse(19'h1 << 9);
    service(9);
    $display("test strobes done");
  endtask : t_strobes
  // Edge select per pin, alternating rising and falling
  task automatic t_pins();
    for (int p = 0; p < 6; p++)
    begin
      apb(1'b1, VITF_OFF_EDGE, (p % 2) ? 32'h100 << p : 32'h1 << p);
      ext_pin[p] <= 1'b1;
      repeat (8) @(posedge pclk);
      ext_pin[p] <= 1'b0;
      repeat (8) @(posedge pclk);
      rd(VITF_OFF_REQ, 32'h2 << p);
      service(p + 1);
    end
    // Both edges selected on one pin: each edge requests once
    apb(1'b1, VITF_OFF_EDGE, 32'h101);
    ext_pin[0] <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(VITF_OFF_REQ, 32'h2);
    apb(1'b1, VITF_OFF_REQ, 32'h2);
    rd(VITF_OFF_REQ, 32'h0);
    ext_pin[0] <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(VITF_OFF_REQ, 32'h2);
    service(1);
    $display("test pins done");
  endtask : t_pins
  task automatic prio_pair(input logic [31:0] pr, input int w1, input int w2);
    dly <= 4'h3;
    apb(1'b1, VITF_OFF_PRIO, pr);
    pulse(19'h8080);
    apb(1'b1, VITF_OFF_MASK, 32'h17f7f);
    n = acks;
    apb(1'b1, VITF_OFF_CTRL, 32'h3);
    wait_ack(n);
    chk_out(taken_vector, exp_vector(w1));
    rd(VITF_OFF_REQ, 32'h1 << w2);
    if (!pr[w1])
    begin
      apb(1'b1, VITF_OFF_CTRL, 32'h1);
      repeat (3) @(posedge pclk);
      chk_out(16'(intr_req), 16'h0);
    end
    n = acks;
    apb(1'b1, VITF_OFF_CTRL, 32'h3);
    wait_ack(n);
    chk_out(taken_vector, exp_vector(w2));
    apb(1'b1, VITF_OFF_MASK, 32'h1ffff);
    dly <= 4'h0;
    $display("test priority done");
  endtask : prio_pair
  // Non-maskable with enable off, then break
  task automatic t_nmi_brk();
    apb(1'b1, VITF_OFF_CTRL, 32'h4);
    n = acks;
    pulse(19'h1);
    wait_ack(n);
    chk_out(taken_vector, 16'h0004);
    chk_out(16'(taken_nmi), 16'h1);
    n = acks;
    pulse(19'h1 << 17);
    wait_ack(n);
    chk_out(taken_vector, 16'h003e);
    chk_out(16'(taken_nmi), 16'h0);
    $display("test nmi done");
  endtask : t_nmi_brk
  // Test flags: set without vector, stay until cleared
  task automatic t_flags();
    apb(1'b1, VITF_OFF_TEST, 32'h0);
    n = acks;
    p11[3] <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(VITF_OFF_TEST, 32'h2);
    chk_out(16'(test_pending), 16'h2);
    pulse(19'h1 << 18);
    repeat (4) @(posedge pclk);
    chk_out(16'(test_pending), 16'h3);
    chk_out(16'(acks), 16'(n));
    apb(1'b1, VITF_OFF_TEST, 32'h3);
    rd(VITF_OFF_TEST, 32'h0);
    p11[3] <= 1'b1;
    $display("test flags done");
  endtask : t_flags
  // Bound on the whole run
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_strobes();
    t_pins();
    prio_pair(32'h1ffff, 7, 15);
    prio_pair(32'h17fff, 15, 7);
    t_nmi_brk();
    t_flags();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
